/* File: design/sbc_shunt_b_config_cal.sv */
/*
  sbc_shunt_b_config_cal: configuration and calibration registers of the
  second shunt converter channel, with the correction of its conversion
  results, behind an AXI4-Lite slave.
  Assumes the converter front end delivers raw 24-bit samples on clk with a
  one-cycle valid, and that the analog switches and current DACs are driven
  from the decoded outputs below.
*/
// Our own choice: the AXI4-Lite register port.
module sbc_shunt_b_config_cal
  import sbc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // raw samples from the converter front end
  input wire logic [23:0] raw_sample,
  input wire logic raw_sample_valid,
  // corrected result
  output logic [23:0] conversion_result,
  output logic [1:0] shunt_b_conversion_counter,
  output logic result_strobe,
  // analog control
  output logic shunt_b_channel_enable,
  output logic analog_gain_is_8,
  output logic route_direct,
  output logic route_swapped,
  output logic route_short_ground,
  output logic route_test_dac,
  output logic source_to_negative_pin,
  output logic sink_to_negative_pin,
  output logic source_4ua,
  output logic source_240ua,
  output logic sink_4ua,
  output logic sink_40ua,
  output logic sink_240ua,
  output logic [23:0] shunt_b_offset_correction,
  output logic [15:0] shunt_b_gain_correction
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the index decode reads address bits 11 to 2, so narrower buses cannot be served
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 12 and 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ocal_hi;
    logic [7:0] ocal_lo;
    logic [15:0] gcal;
    logic [1:0] pwr;
    logic [23:0] result;
    logic [1:0] count;
    logic strobe;
    logic aw_seen;
    logic [ADDR_W-1:0] aw_addr;
    logic w_seen;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sbc_state_t;

  sbc_state_t s_r;
  sbc_state_t s_nxt;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // byte lane merge of a 16-bit register, reserved bits kept at zero
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    merge16 = v & mask;
  endfunction

  // register index of a byte address, all ones when not word aligned
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = (a[1:0] == 2'h0) ? a[11:2] : 10'h3FF;
  endfunction

  // clamp a wide signed value to 24 bits
  function automatic logic [23:0] sat24(input logic signed [45:0] v);
    if (v > 46'sh0000007FFFFF) begin
      sat24 = 24'h7FFFFF;
    end else if (v < -46'sh000000800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  logic [1:0] gain_code;
  logic [1:0] sel_code;
  logic [1:0] src_lvl;
  logic [1:0] snk_lvl;
  logic active;
  assign gain_code = s_r.cfg[POS_GAIN +: 2];
  assign sel_code = s_r.cfg[POS_INPUT_SEL +: 2];
  assign src_lvl = s_r.cfg[POS_SOURCE_LEVEL +: 2];
  assign snk_lvl = s_r.cfg[POS_SINK_LEVEL +: 2];
  // channel runs only when enabled and neither standby nor power-down
  assign active = s_r.cfg[POS_ENABLE] && !s_r.pwr[POS_STANDBY] && !s_r.pwr[POS_POWERDOWN];

  // ----------------------------------------------------------------
  // correction datapath
  // ----------------------------------------------------------------
  logic [1:0] dig_shift;
  logic signed [26:0] scaled;
  logic signed [23:0] offset_word;
  logic signed [27:0] offset_removed;
  logic signed [17:0] gain_factor;
  logic signed [45:0] product;
  logic signed [45:0] product_scaled;

  // digital multiply by 2 or 4 on top of analog gain 8
  assign dig_shift = (gain_code == GAIN_16) ? 2'h1 : (gain_code == GAIN_32) ? 2'h2 : 2'h0;
  assign scaled = $signed({{3{raw_sample[23]}}, raw_sample}) <<< dig_shift;
  assign offset_word = $signed({s_r.ocal_hi, s_r.ocal_lo});
  assign offset_removed = $signed({scaled[26], scaled}) - $signed({{4{offset_word[23]}}, offset_word});
  // factor one plus code over 65536, spans 0.5 to just under 1.5
  assign gain_factor = 18'sh10000 + $signed({{2{s_r.gcal[15]}}, s_r.gcal});
  assign product = offset_removed * gain_factor;
  assign product_scaled = product >>> 16;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [15:0] lo_merged;
  logic [15:0] pwr_merged;

  assign s_axi_awready = !s_r.aw_seen && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_seen && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_addr = s_r.aw_seen ? s_r.aw_addr : s_axi_awaddr;
  assign wr_data = s_r.w_seen ? s_r.w_data : s_axi_wdata[15:0];
  assign wr_strb = s_r.w_seen ? s_r.w_strb : s_axi_wstrb[1:0];
  assign wr_idx = word_index(wr_addr);
  assign rd_idx = word_index(s_axi_araddr);
  // merged words of the narrow registers, sliced where they are stored
  assign lo_merged = merge16({s_r.ocal_lo, 8'h00}, wr_data, wr_strb, WMASK_OFFSET_CAL_LOW);
  assign pwr_merged = merge16({14'h0, s_r.pwr}, wr_data, wr_strb, WMASK_POWER_MODE);

  // bus slave, register writes and result update
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe = 1'b0;
    // write channel: address and data in either order
    if (aw_fire) begin
      s_nxt.aw_seen = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_nxt.w_seen = 1'b1;
      s_nxt.w_data = s_axi_wdata[15:0];
      s_nxt.w_strb = s_axi_wstrb[1:0];
    end
    if ((s_r.aw_seen || aw_fire) && (s_r.w_seen || w_fire)) begin
      s_nxt.aw_seen = 1'b0;
      s_nxt.w_seen = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (wr_idx)
        IDX_CHANNEL_CONFIG: s_nxt.cfg = merge16(s_r.cfg, wr_data, wr_strb, WMASK_CHANNEL_CONFIG);
        IDX_OFFSET_CAL_HIGH: s_nxt.ocal_hi = merge16(s_r.ocal_hi, wr_data, wr_strb, 16'hFFFF);
        IDX_OFFSET_CAL_LOW: s_nxt.ocal_lo = lo_merged[15:8];
        IDX_GAIN_CAL: s_nxt.gcal = merge16(s_r.gcal, wr_data, wr_strb, 16'hFFFF);
        IDX_POWER_MODE: s_nxt.pwr = pwr_merged[1:0];
        IDX_RESULT, IDX_STATUS: s_nxt.bresp = RESP_OKAY; // read-only, write dropped
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // read channel: answer one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h00000000;
      unique case (rd_idx)
        IDX_CHANNEL_CONFIG: s_nxt.rdata[15:0] = s_r.cfg & WMASK_CHANNEL_CONFIG;
        IDX_OFFSET_CAL_HIGH: s_nxt.rdata[15:0] = s_r.ocal_hi;
        IDX_OFFSET_CAL_LOW: s_nxt.rdata[15:0] = {s_r.ocal_lo, 8'h00};
        IDX_GAIN_CAL: s_nxt.rdata[15:0] = s_r.gcal;
        IDX_RESULT: s_nxt.rdata[23:0] = s_r.result;
        IDX_STATUS: s_nxt.rdata[2:0] = {active, s_r.count};
        IDX_POWER_MODE: s_nxt.rdata[1:0] = s_r.pwr;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    // conversion result and counter
    if (!active) begin
      s_nxt.result = 24'h000000;
      s_nxt.count = 2'h0;
    end else if (raw_sample_valid) begin
      s_nxt.result = sat24(product_scaled);
      s_nxt.count = s_r.count + 2'h1;
      s_nxt.strobe = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.cfg <= RST_CHANNEL_CONFIG;
      s_r.ocal_hi <= RST_OFFSET_CAL_HIGH;
      s_r.ocal_lo <= RST_OFFSET_CAL_LOW[15:8];
      s_r.gcal <= RST_GAIN_CAL;
      s_r.pwr <= RST_POWER_MODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign conversion_result = s_r.result;
  assign shunt_b_conversion_counter = s_r.count;
  assign result_strobe = s_r.strobe;
  assign shunt_b_channel_enable = active;
  assign shunt_b_offset_correction = {s_r.ocal_hi, s_r.ocal_lo};
  assign shunt_b_gain_correction = s_r.gcal;

  // analog gain 4 only for code 00, otherwise 8
  assign analog_gain_is_8 = (gain_code != GAIN_4);

  // input multiplexer, one-hot
  assign route_direct = (sel_code == SEL_DIRECT);
  assign route_swapped = (sel_code == SEL_SWAPPED);
  assign route_short_ground = (sel_code == SEL_SHORT);
  assign route_test_dac = (sel_code == SEL_TEST_DAC);

  // open-wire diagnostic current steering and magnitude
  assign source_to_negative_pin = s_r.cfg[POS_SOURCE_ROUTE];
  assign sink_to_negative_pin = s_r.cfg[POS_SINK_ROUTE];
  assign source_4ua = (src_lvl == LVL_4UA);
  assign source_240ua = (src_lvl == LVL_40UA) || (src_lvl == LVL_240UA);
  assign sink_4ua = (snk_lvl == LVL_4UA);
  assign sink_40ua = (snk_lvl == LVL_40UA);
  assign sink_240ua = (snk_lvl == LVL_240UA);

endmodule

/* File: design/sbc_pkg.sv */
/*
  sbc_pkg: shared constants for the shunt converter b configuration and
  calibration block: register indices, field positions, field encodings,
  reset values, writable masks and bus response codes.
  Assumes a 32-bit register bus with one aligned word per register.
*/
package sbc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CHANNEL_CONFIG = 10'h0C3;
  localparam logic [9:0] IDX_OFFSET_CAL_HIGH = 10'h0C4;
  localparam logic [9:0] IDX_OFFSET_CAL_LOW = 10'h0C5;
  localparam logic [9:0] IDX_GAIN_CAL = 10'h0C6;
  localparam logic [9:0] IDX_RESULT = 10'h100;
  localparam logic [9:0] IDX_STATUS = 10'h101;
  localparam logic [9:0] IDX_POWER_MODE = 10'h102;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CHANNEL_CONFIG = 16'h8010;
  localparam logic [15:0] RST_OFFSET_CAL_HIGH = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CAL_LOW = 16'h0000;
  localparam logic [15:0] RST_GAIN_CAL = 16'h0000;
  localparam logic [1:0] RST_POWER_MODE = 2'h0;
  localparam logic [15:0] WMASK_CHANNEL_CONFIG = 16'h8F3F;
  localparam logic [15:0] WMASK_OFFSET_CAL_LOW = 16'hFF00;
  localparam logic [15:0] WMASK_POWER_MODE = 16'h0003;

  // ----------------------------------------------------------------
  // channel configuration and power mode field positions
  // ----------------------------------------------------------------
  localparam int POS_ENABLE = 15;
  localparam int POS_GAIN = 10;
  localparam int POS_INPUT_SEL = 8;
  localparam int POS_SOURCE_ROUTE = 5;
  localparam int POS_SINK_ROUTE = 4;
  localparam int POS_SOURCE_LEVEL = 2;
  localparam int POS_SINK_LEVEL = 0;
  localparam int POS_STANDBY = 0;
  localparam int POS_POWERDOWN = 1;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_4 = 2'h0;
  localparam logic [1:0] GAIN_8 = 2'h1;
  localparam logic [1:0] GAIN_16 = 2'h2;
  localparam logic [1:0] GAIN_32 = 2'h3;
  localparam logic [1:0] SEL_DIRECT = 2'h0;
  localparam logic [1:0] SEL_SWAPPED = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] SEL_TEST_DAC = 2'h3;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_4UA = 2'h1;
  localparam logic [1:0] LVL_40UA = 2'h2;
  localparam logic [1:0] LVL_240UA = 2'h3;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: verification/sbc_chk.sv */
/*
  sbc_chk: port-level assertions for the shunt b configuration block.
  Assumes it is bound to sbc_shunt_b_config_cal and sees only its ports.
*/
module sbc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sample path
  input wire logic [23:0] raw_sample,
  input wire logic raw_sample_valid,
  input wire logic [23:0] conversion_result,
  input wire logic [1:0] shunt_b_conversion_counter,
  input wire logic result_strobe,
  // decoded controls
  input wire logic shunt_b_channel_enable,
  input wire logic analog_gain_is_8,
  input wire logic route_direct,
  input wire logic route_swapped,
  input wire logic route_short_ground,
  input wire logic route_test_dac,
  input wire logic source_4ua,
  input wire logic source_240ua,
  input wire logic sink_4ua,
  input wire logic sink_40ua,
  input wire logic sink_240ua,
  input wire logic [23:0] shunt_b_offset_correction,
  input wire logic [15:0] shunt_b_gain_correction
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  route_onehot_a: assert property ($onehot({route_test_dac, route_short_ground, route_swapped, route_direct}))
    else $error("input routes not one-hot");
  source_level_a: assert property (!(source_4ua && source_240ua))
    else $error("two source levels at once");
  sink_level_a: assert property ($onehot0({sink_240ua, sink_40ua, sink_4ua}))
    else $error("two sink levels at once");
  clear_idle_a: assert property (!shunt_b_channel_enable
    |=> conversion_result == 24'h000000 && shunt_b_conversion_counter == 2'h0)
    else $error("result or counter not cleared while inactive");
  count_step_a: assert property (raw_sample_valid && shunt_b_channel_enable
    |=> result_strobe && shunt_b_conversion_counter == $past(shunt_b_conversion_counter) + 2'h1)
    else $error("accepted sample did not step the counter");
  no_strobe_a: assert property (!(raw_sample_valid && shunt_b_channel_enable) |=> !result_strobe)
    else $error("strobe without accepted sample");
  unity_path_a: assert property (raw_sample_valid && shunt_b_channel_enable && !analog_gain_is_8
    && shunt_b_offset_correction == 24'h000000 && shunt_b_gain_correction == 16'h0000
    |=> conversion_result == $past(raw_sample))
    else $error("neutral calibration altered the sample");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule

/* File: verification/sbc_shunt_b_config_cal_tb.sv */
/*
  sbc_shunt_b_config_cal_tb: register and sample-path tests over axi4-lite.
  Assumes sbc_pkg, the design and sbc_chk are compiled before it.
*/
module sbc_shunt_b_config_cal_tb import sbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus, design and helpers
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [23:0] raw_sample = 24'h0;
  logic raw_sample_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, result_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp, shunt_b_conversion_counter;
  logic [31:0] s_axi_rdata;
  logic [23:0] conversion_result, shunt_b_offset_correction;
  logic [15:0] shunt_b_gain_correction;
  logic shunt_b_channel_enable, analog_gain_is_8, route_direct, route_swapped, route_short_ground;
  logic route_test_dac, source_to_negative_pin, sink_to_negative_pin, source_4ua, source_240ua;
  logic sink_4ua, sink_40ua, sink_240ua;
  logic [1:0] k;
  int n_errors = 0;
  int tests_run = 0;
  int cnt = 0;
  int c;

  // free-running clock
  always #2 clk = ~clk;

  sbc_shunt_b_config_cal sbc_shunt_b_config_cal_i (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .raw_sample, .raw_sample_valid, .conversion_result, .shunt_b_conversion_counter, .result_strobe,
    .shunt_b_channel_enable, .analog_gain_is_8, .route_direct, .route_swapped, .route_short_ground,
    .route_test_dac, .source_to_negative_pin, .sink_to_negative_pin, .source_4ua, .source_240ua, .sink_4ua,
    .sink_40ua, .sink_240ua, .shunt_b_offset_correction, .shunt_b_gain_correction);

  // verdict and end of run
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask

  // axi4-lite write; handshakes sampled at the falling edge, acted on at the rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int i;
    tb = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !tb; i++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) begin
      n_errors++;
      close_out();
    end
  endtask

  // axi4-lite read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    int i;
    tr = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !tr; i++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk("rdata", e, s_axi_rdata);
      if (tr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) begin
      n_errors++;
      close_out();
    end
  endtask

  // one raw sample, then result and counter compared
  task automatic smp(input logic [23:0] v, input logic [23:0] e, input logic on);
    @(posedge clk);
    raw_sample <= v;
    raw_sample_valid <= 1'b1;
    @(posedge clk);
    raw_sample_valid <= 1'b0;
    @(negedge clk);
    if (on) cnt = (cnt + 1) % 4;
    chk("result", {8'h0, e}, {8'h0, conversion_result});
    chk("counter", cnt, {30'h0, shunt_b_conversion_counter});
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(12'h30C, 32'h8010, RESP_OKAY);
    rd(12'h314, 32'h0, RESP_OKAY);
    chk("sink_route", 32'h1, {31'h0, sink_to_negative_pin});
    wr(12'h30C, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h30C, 32'h8F3F, RESP_OKAY);
    for (c = 0; c < 4; c++) begin
      k = c[1:0];
      wr(12'h30C, {16'h0, 1'b1, 3'h0, k, k, 4'h0, k, k}, RESP_OKAY);
      chk("gain8", {31'h0, k != 2'h0}, {31'h0, analog_gain_is_8});
      chk("route", 32'h1 << c, {28'h0, route_test_dac, route_short_ground, route_swapped, route_direct});
      chk("source", {30'h0, k == 2'h1, k[1]}, {30'h0, source_4ua, source_240ua});
      chk("sink", (c == 0) ? 32'h0 : 32'h1 << (c - 1), {29'h0, sink_240ua, sink_40ua, sink_4ua});
      smp(24'h000100, 24'h000100 << ((c > 1) ? c - 1 : 0), 1'b1);
    end
    wr(12'h30C, 32'h8030, RESP_OKAY);
    chk("source_route", 32'h1, {31'h0, source_to_negative_pin});
    wr(12'h30C, 32'h8000, RESP_OKAY);
    chk("sink_route", 32'h0, {31'h0, sink_to_negative_pin});
    wr(12'h310, 32'h0000FFFF, RESP_OKAY);
    rd(12'h310, 32'hFFFF, RESP_OKAY);
    wr(12'h314, 32'h000080FF, RESP_OKAY);
    rd(12'h314, 32'h8000, RESP_OKAY);
    chk("offset", 32'hFFFF80, {8'h0, shunt_b_offset_correction});
    smp(24'h000010, 24'h000090, 1'b1);
    wr(12'h318, 32'h8000, RESP_OKAY);
    smp(24'h000010, 24'h000048, 1'b1);
    wr(12'h318, 32'h7FFF, RESP_OKAY);
    // low byte lane only: the high byte must survive
    s_axi_wstrb <= 4'h1;
    wr(12'h318, 32'h0, RESP_OKAY);
    rd(12'h318, 32'h7F00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    wr(12'h318, 32'h7FFF, RESP_OKAY);
    chk("gain_cal", 32'h7FFF, {16'h0, shunt_b_gain_correction});
    smp(24'h000010, 24'h0000D7, 1'b1);
    wr(12'h500, 32'h1, RESP_SLVERR);
    rd(12'h500, 32'h0, RESP_SLVERR);
    wr(12'h30C, 32'h0, RESP_OKAY);
    chk("enable", 32'h0, {31'h0, shunt_b_channel_enable});
    cnt = 0;
    smp(24'h000010, 24'h0, 1'b0);
    for (c = 1; c < 3; c++) begin
      wr(12'h30C, 32'h8000, RESP_OKAY);
      wr(12'h408, 32'h0, RESP_OKAY);
      smp(24'h000010, 24'h0000D7, 1'b1);
      rd(12'h400, 32'hD7, RESP_OKAY);
      rd(12'h404, 32'h5, RESP_OKAY);
      wr(12'h408, c, RESP_OKAY);
      cnt = 0;
      smp(24'h000010, 24'h0, 1'b0);
      rd(12'h404, 32'h0, RESP_OKAY);
    end
    close_out();
  end
endmodule

// checker on the design's ports
bind sbc_shunt_b_config_cal sbc_chk sbc_chk_i (.clk, .nrst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .raw_sample, .raw_sample_valid, .conversion_result,
  .shunt_b_conversion_counter, .result_strobe, .shunt_b_channel_enable, .analog_gain_is_8, .route_direct,
  .route_swapped, .route_short_ground, .route_test_dac, .source_4ua, .source_240ua, .sink_4ua, .sink_40ua,
  .sink_240ua, .shunt_b_offset_correction, .shunt_b_gain_correction);
